// *** hw/sts_defines.svh ***
`ifndef STS_DEFINES_SVH
`define STS_DEFINES_SVH
`define STS_DW        16
`define STS_AW        3
`define STS_DEPTH     8
`define STS_LW        4
`define STS_CW        17
`define STS_SCK_HALF  4'h4
`define STS_TRANSFER_MODE_FIELD_TXRX 2'h0
`define STS_TRANSFER_MODE_FIELD_TXO  2'h1
`define STS_TRANSFER_MODE_FIELD_RXO  2'h2
`define STS_TRANSFER_MODE_FIELD_EE   2'h3
`endif

// *** hw/sts_pkg.sv ***
`include "sts_defines.svh"
package sts_pkg;
  typedef enum logic [2:0] {
    M_IDLE  = 3'b000,
    M_SHIFT = 3'b001,
    M_FEND  = 3'b010,
    M_POLL  = 3'b011,
    M_DONE  = 3'b100
  } sts_mst_e;
  typedef enum logic [1:0] {
    K_TX   = 2'b00,
    K_CTL  = 2'b01,
    K_MWTX = 2'b10,
    K_RX   = 2'b11
  } sts_kind_e;
  typedef struct packed {
    logic       enable;
    logic       master;
    logic       ssp;
    logic [1:0] transfer_mode_field;
    logic [3:0] len_m1;
    logic [15:0] frame_count_field;
    logic       slv_oe;
  } sts_cfg_s;
  typedef struct packed {
    logic en;
    logic hs;
    logic dir;
    logic seq;
  } sts_mw_s;
  typedef struct packed {
    logic [`STS_LW-1:0] tx_thr;
    logic [`STS_LW-1:0] dma_tx;
    logic [`STS_LW-1:0] rx_thr;
    logic [`STS_LW-1:0] dma_rx;
  } sts_lvl_s;
endpackage : sts_pkg

// *** hw/sts_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
module sts_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,   // core clock
  input  wire logic         rst_b, // sync reset, low
  input  wire logic [W-1:0] d,     // async inputs
  output logic      [W-1:0] q      // synced outputs
);
  logic [W-1:0] s1_reg;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s1_reg <= '0;
      q      <= '0;
    end else begin
      s1_reg <= d;
      q      <= s1_reg;
    end
  end
endmodule // sts_sync
`default_nettype wire

// *** hw/sts_fifo.sv ***
`timescale 1ns/10ps
`default_nettype none
module sts_fifo
  import sts_pkg::*;
(
  input  wire logic               clk,   // core clock
  input  wire logic               rst_b, // sync reset, low
  input  wire logic               push,  // write strobe
  input  wire logic [`STS_DW-1:0] wdata, // write data
  input  wire logic               pop,   // read strobe
  output logic      [`STS_DW-1:0] rdata, // head entry
  output logic      [`STS_LW-1:0] level, // entries held
  output logic                    full,  // no room
  output logic                    empty  // nothing held
);
  logic [`STS_DW-1:0] mem [`STS_DEPTH];
  logic [`STS_AW-1:0] wp_reg;
  logic [`STS_AW-1:0] rp_reg;
  logic [`STS_LW-1:0] cnt_reg;
  logic               do_push;
  logic               do_pop;
  assign full    = (cnt_reg == `STS_LW'(`STS_DEPTH));
  assign empty   = (cnt_reg == '0);
  assign do_push = push && !full;
  assign do_pop  = pop && !empty;
  assign rdata   = mem[rp_reg];
  assign level   = cnt_reg;
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wp_reg] <= wdata;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (do_push) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (do_pop) begin
        rp_reg <= rp_reg + 1'b1;
      end
      if (do_push && !do_pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (do_pop && !do_push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule // sts_fifo
`default_nettype wire

// *** hw/sts_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module sts_top
  import sts_pkg::*;
(
  input  wire logic               CORE_CLK,   // core clock
  input  wire logic               RST_B,      // sync reset, low
  input  wire sts_cfg_s           CFG,        // general configuration
  input  wire sts_mw_s            MW,         // three-wire control
  input  wire sts_lvl_s           LVL,        // fifo thresholds
  input  wire logic               SLV_SEL,    // software selects a slave
  input  wire logic               TX_WR,      // push transmit word
  input  wire logic [`STS_DW-1:0] TX_WDATA,   // transmit word
  input  wire logic               RX_RD,      // pop receive word
  input  wire logic               TXE_CLR,    // clear tx empty error
  output logic      [`STS_DW-1:0] RX_RDATA,   // popped receive word
  output logic                    TX_FULL,    // transmit fifo full
  output logic                    RX_EMPTY,   // receive fifo empty
  output logic      [`STS_LW-1:0] TX_LEVEL,   // transmit entries
  output logic      [`STS_LW-1:0] RX_LEVEL,   // receive entries
  output logic                    BUSY,       // master transfer active
  output logic                    TXE_ERR,    // slave tx empty error
  output logic                    TX_INT,     // tx fifo nearly empty
  output logic                    RX_INT,     // rx fifo nearly full
  output logic                    DMA_TX_REQ, // dma refill request
  output logic                    DMA_RX_REQ, // dma drain request
  output logic                    SCLK_OUT,   // master serial clock
  output logic                    SS_OUT_N,   // master slave select, low
  output logic                    TXD_O,      // serial data out
  output logic                    TXD_OE,     // data out enable, high
  input  wire logic               RXD,        // serial data in
  input  wire logic               SCLK_IN,    // slave serial clock
  input  wire logic               SS_IN_N     // slave select in, low
);
  logic [2:0]         pin_s;
  logic               sclk_s;
  logic               ss_s;
  logic               rxd_s;
  logic [`STS_DW-1:0] tx_rdata;
  logic [`STS_LW-1:0] tx_level;
  logic [`STS_LW-1:0] rx_level;
  logic               tx_full;
  logic               tx_empty;
  logic               rx_full;
  logic               rx_empty;
  logic               tx_pop;
  logic               rx_push;
  logic [`STS_DW-1:0] rx_wdata;
  logic [`STS_DW-1:0] rx_rdata;
  logic [1:0]         transfer_mode_field;
  // master
  sts_mst_e           st_reg;
  sts_kind_e          kind_reg;
  sts_kind_e          nxt_kind;
  logic               nxt_end;
  logic               nxt_pop;
  logic [3:0]         div_reg;
  logic               sclk_reg;
  logic [3:0]         bit_reg;
  logic [`STS_DW-1:0] m_sh_reg;
  logic [`STS_DW-1:0] m_rx_reg;
  logic [`STS_CW-1:0] cnt_reg;
  logic [`STS_CW-1:0] ndf_p1;
  logic               cnt_done;
  logic               m_act;
  logic               m_start;
  logic               tick;
  logic               m_rise;
  logic               m_fend;
  logic               m_store;
  logic               m_pop;
  // slave
  logic               s_act;
  logic               s_sel;
  logic               sel_d_reg;
  logic               sclk_d_reg;
  logic               s_rise;
  logic               s_fall;
  logic               s_fend;
  logic               s_load;
  logic               s_pop;
  logic [3:0]         s_bit_reg;
  logic [`STS_DW-1:0] s_sh_reg;
  logic [`STS_DW-1:0] s_prev_reg;
  logic [`STS_DW-1:0] s_rx_reg;

  sts_sync #(.W(3)) u_sync (
    .clk   (CORE_CLK),
    .rst_b (RST_B),
    .d     ({SCLK_IN, SS_IN_N, RXD}),
    .q     (pin_s)
  );
  assign sclk_s = pin_s[2];
  assign ss_s   = pin_s[1];
  assign rxd_s  = pin_s[0];

  sts_fifo u_txf (
    .clk   (CORE_CLK),
    .rst_b (RST_B),
    .push  (TX_WR),
    .wdata (TX_WDATA),
    .pop   (tx_pop),
    .rdata (tx_rdata),
    .level (tx_level),
    .full  (tx_full),
    .empty (tx_empty)
  );
  sts_fifo u_rxf (
    .clk   (CORE_CLK),
    .rst_b (RST_B),
    .push  (rx_push),
    .wdata (rx_wdata),
    .pop   (RX_RD),
    .rdata (rx_rdata),
    .level (rx_level),
    .full  (rx_full),
    .empty (rx_empty)
  );

  // eeprom read falls back to transmit-and-receive in frame-pulse format
  assign transfer_mode_field = (CFG.ssp && CFG.transfer_mode_field == `STS_TRANSFER_MODE_FIELD_EE) ? `STS_TRANSFER_MODE_FIELD_TXRX : CFG.transfer_mode_field;
  assign m_act = CFG.enable && CFG.master;
  assign s_act = CFG.enable && !CFG.master;

  // ---------------- master sequencer ----------------
  assign m_start = m_act && st_reg == M_IDLE && !tx_empty && SLV_SEL;
  assign tick    = div_reg == `STS_SCK_HALF;
  assign m_rise  = st_reg == M_SHIFT && tick && !sclk_reg;
  assign m_fend  = st_reg == M_SHIFT && tick && sclk_reg && bit_reg == '0;
  assign m_store = kind_reg == K_RX ||
                   (kind_reg == K_TX && !MW.en && transfer_mode_field == `STS_TRANSFER_MODE_FIELD_TXRX);
  assign ndf_p1  = {1'b0, CFG.frame_count_field} + 17'h0_0001;
  assign cnt_done = cnt_reg == ndf_p1;

  always_comb begin
    nxt_kind = K_TX;
    nxt_end  = 1'b0;
    nxt_pop  = 1'b0;
    if (MW.en) begin
      if (kind_reg == K_CTL) begin
        nxt_kind = MW.dir ? K_MWTX : K_RX;
        nxt_end  = MW.dir && tx_empty;
        nxt_pop  = MW.dir && !tx_empty;
      end else if (MW.seq && !MW.dir) begin
        nxt_kind = K_RX;
        nxt_end  = cnt_done;
      end else begin
        nxt_kind = K_CTL;
        nxt_end  = tx_empty;
        nxt_pop  = !tx_empty;
      end
    end else begin
      case (transfer_mode_field)
        `STS_TRANSFER_MODE_FIELD_TXRX, `STS_TRANSFER_MODE_FIELD_TXO: begin
          nxt_kind = K_TX;
          nxt_end  = tx_empty;
          nxt_pop  = !tx_empty;
        end
        `STS_TRANSFER_MODE_FIELD_RXO: begin
          nxt_kind = K_RX;
          nxt_end  = cnt_done;
        end
        `STS_TRANSFER_MODE_FIELD_EE: begin
          if (kind_reg == K_TX) begin
            nxt_kind = tx_empty ? K_RX : K_TX;
            nxt_pop  = !tx_empty;
          end else begin
            nxt_kind = K_RX;
            nxt_end  = cnt_done;
          end
        end
        default: begin
          nxt_end = 1'b1;
        end
      endcase
    end
  end

  assign m_pop = m_start ||
                 ((st_reg == M_FEND || (st_reg == M_POLL && rxd_s)) &&
                  !(st_reg == M_FEND && MW.en && MW.hs && kind_reg != K_CTL) &&
                  !nxt_end && nxt_pop);

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      st_reg   <= M_IDLE;
      kind_reg <= K_TX;
      BUSY     <= 1'b0;
      SS_OUT_N <= 1'b1;
    end else if (!m_act) begin
      st_reg   <= M_IDLE;
      BUSY     <= 1'b0;
      SS_OUT_N <= 1'b1;
    end else begin
      case (st_reg)
        M_IDLE: begin
          if (m_start) begin
            st_reg   <= M_SHIFT;
            BUSY     <= 1'b1;
            SS_OUT_N <= 1'b0;
            kind_reg <= MW.en ? K_CTL : (transfer_mode_field == `STS_TRANSFER_MODE_FIELD_RXO ? K_RX : K_TX);
          end
        end
        M_SHIFT: begin
          if (m_fend) begin
            st_reg <= M_FEND;
          end
        end
        M_FEND, M_POLL: begin
          if (st_reg == M_FEND && MW.en && MW.hs && kind_reg != K_CTL) begin
            st_reg <= M_POLL;
          end else if (st_reg == M_POLL && !rxd_s) begin
            st_reg <= M_POLL;
          end else if (nxt_end) begin
            st_reg   <= M_DONE;
            BUSY     <= 1'b0;
            SS_OUT_N <= 1'b1;
          end else begin
            st_reg   <= M_SHIFT;
            kind_reg <= nxt_kind;
          end
        end
        M_DONE: begin
          st_reg <= M_IDLE;
        end
        default: begin
          st_reg <= M_IDLE;
        end
      endcase
    end
  end

  // serial clock, bit counter and shift registers of the master
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      div_reg  <= '0;
      sclk_reg <= 1'b0;
      bit_reg  <= '0;
      m_sh_reg <= '0;
      m_rx_reg <= '0;
    end else if (st_reg != M_SHIFT) begin
      div_reg  <= '0;
      sclk_reg <= 1'b0;
      bit_reg  <= CFG.len_m1;
      m_rx_reg <= '0;
      if (m_pop) begin
        // receive frames shift zeros so txd stays low
        m_sh_reg <= (m_start && transfer_mode_field == `STS_TRANSFER_MODE_FIELD_RXO && !MW.en) ? '0 : tx_rdata;
      end else if (st_reg != M_IDLE) begin
        m_sh_reg <= '0;
      end
    end else if (tick) begin
      div_reg  <= '0;
      sclk_reg <= !sclk_reg;
      if (!sclk_reg) begin
        m_rx_reg <= {m_rx_reg[`STS_DW-2:0], rxd_s};
      end else if (bit_reg != '0) begin
        bit_reg  <= bit_reg - 1'b1;
        m_sh_reg <= {m_sh_reg[`STS_DW-2:0], 1'b0};
      end
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B || m_start) begin
      cnt_reg <= '0;
    end else if (m_fend && kind_reg == K_RX) begin
      cnt_reg <= cnt_reg + 17'h0_0001;
    end
  end

  // ---------------- slave ----------------
  assign s_sel  = s_act && !ss_s;
  assign s_rise = s_sel && sclk_s && !sclk_d_reg;
  assign s_fall = s_sel && !sclk_s && sclk_d_reg;
  assign s_fend = s_fall && s_bit_reg == '0;
  assign s_load = (s_sel && !sel_d_reg) || s_fend;
  assign s_pop  = s_load && transfer_mode_field != `STS_TRANSFER_MODE_FIELD_RXO && !tx_empty;

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      sel_d_reg  <= 1'b0;
      sclk_d_reg <= 1'b0;
      s_bit_reg  <= '0;
      s_sh_reg   <= '0;
      s_prev_reg <= '0;
      s_rx_reg   <= '0;
    end else begin
      sel_d_reg  <= s_sel;
      sclk_d_reg <= sclk_s;
      if (s_load) begin
        s_bit_reg <= CFG.len_m1;
        s_rx_reg  <= '0;
        if (s_pop) begin
          s_sh_reg   <= tx_rdata;
          s_prev_reg <= tx_rdata;
        end else begin
          s_sh_reg <= s_prev_reg;
        end
      end else if (s_rise) begin
        s_rx_reg <= {s_rx_reg[`STS_DW-2:0], rxd_s};
      end else if (s_fall) begin
        s_bit_reg <= s_bit_reg - 1'b1;
        s_sh_reg  <= {s_sh_reg[`STS_DW-2:0], 1'b0};
      end
    end
  end

  // set wins over software clear
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      TXE_ERR <= 1'b0;
    end else begin
      TXE_ERR <= (s_load && transfer_mode_field != `STS_TRANSFER_MODE_FIELD_RXO && tx_empty) || (TXE_ERR && !TXE_CLR);
    end
  end

  // ---------------- shared fifo paths ----------------
  assign tx_pop   = m_act ? m_pop : s_pop;
  assign rx_push  = m_act ? (m_fend && m_store) : (s_fend && transfer_mode_field != `STS_TRANSFER_MODE_FIELD_TXO);
  assign rx_wdata = m_act ? m_rx_reg : s_rx_reg;

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      SCLK_OUT <= 1'b0;
      TXD_O    <= 1'b0;
      TXD_OE   <= 1'b0;
    end else begin
      SCLK_OUT <= m_act && sclk_reg;
      TXD_O    <= m_act ? m_sh_reg[CFG.len_m1] : s_sh_reg[CFG.len_m1];
      TXD_OE   <= m_act || (s_sel && CFG.slv_oe);
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      RX_RDATA   <= '0;
      TX_FULL    <= 1'b0;
      RX_EMPTY   <= 1'b1;
      TX_LEVEL   <= '0;
      RX_LEVEL   <= '0;
      TX_INT     <= 1'b0;
      RX_INT     <= 1'b0;
      DMA_TX_REQ <= 1'b0;
      DMA_RX_REQ <= 1'b0;
    end else begin
      if (RX_RD && !rx_empty) begin
        RX_RDATA <= rx_rdata;
      end
      TX_FULL    <= tx_full;
      RX_EMPTY   <= rx_empty;
      TX_LEVEL   <= tx_level;
      RX_LEVEL   <= rx_level;
      TX_INT     <= tx_level <= LVL.tx_thr;
      DMA_TX_REQ <= tx_level <= LVL.dma_tx;
      RX_INT     <= rx_level >= LVL.rx_thr || rx_full;
      DMA_RX_REQ <= rx_level >= LVL.dma_rx;
    end
  end
endmodule // sts_top
`default_nettype wire

// *** sim/sts_slave_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module sts_slave_model (
  input  wire logic        sclk,  // serial clock from master
  input  wire logic        ss_n,  // select from master, low
  input  wire logic        txd,   // master data out
  input  wire logic [15:0] word,  // word returned each frame
  input  wire logic [4:0]  nbits, // bits per frame
  output var  logic        rxd,   // data back to master
  output var  logic [15:0] got,   // last frame captured
  output var  int          nfr    // frames captured
);
  int          cnt;
  logic [15:0] sh;
  initial begin
    rxd = 1'b1;
    got = 16'h0000;
    nfr = 0;
    cnt = 0;
    sh  = 16'h0000;
  end
  // first bit is ready before the first rising edge
  always @(negedge ss_n) begin
    cnt = 0;
    rxd = word[nbits-1];
  end
  // released line: show the inverse of the last value
  always @(posedge ss_n) begin
    cnt = 0;
    rxd = ~rxd;
  end
  always @(posedge sclk) begin
    if (!ss_n) begin
      sh  = {sh[14:0], txd};
      cnt = cnt + 1;
      if (cnt == int'(nbits)) begin
        got = sh & 16'((32'h0000_0001 << nbits) - 1);
        nfr = nfr + 1;
        cnt = 0;
      end
    end
  end
  always @(negedge sclk) begin
    if (!ss_n) begin
      rxd = word[int'(nbits) - 1 - cnt];
    end
  end
endmodule // sts_slave_model
`default_nettype wire

// *** sim/sts_checker.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "sts_defines.svh"
module sts_checker
  import sts_pkg::*;
(
  input wire logic               CORE_CLK,   // core clock
  input wire logic               RST_B,      // sync reset, low
  input wire sts_cfg_s           CFG,        // configuration
  input wire sts_mw_s            MW,         // three-wire control
  input wire sts_lvl_s           LVL,        // thresholds
  input wire logic               SLV_SEL,    // slave selected
  input wire logic               TXE_CLR,    // error clear
  input wire logic               SS_IN_N,    // slave select in
  input wire logic [`STS_LW-1:0] TX_LEVEL,   // tx entries
  input wire logic [`STS_LW-1:0] RX_LEVEL,   // rx entries
  input wire logic               BUSY,       // transfer active
  input wire logic               TXE_ERR,    // tx empty error
  input wire logic               TX_INT,     // tx nearly empty
  input wire logic               RX_INT,     // rx nearly full
  input wire logic               DMA_TX_REQ, // dma refill
  input wire logic               DMA_RX_REQ, // dma drain
  input wire logic               SCLK_OUT,   // master clock
  input wire logic               SS_OUT_N,   // master select
  input wire logic               TXD_O,      // data out
  input wire logic               TXD_OE      // data out enable
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  a_tx_int_level: assert property ($past(RST_B) && $stable(TX_LEVEL) && $stable(LVL)
    |-> TX_INT == (TX_LEVEL <= LVL.tx_thr)) else $error("tx threshold flag wrong");
  a_dma_tx_level: assert property ($past(RST_B) && $stable(TX_LEVEL) && $stable(LVL)
    |-> DMA_TX_REQ == (TX_LEVEL <= LVL.dma_tx)) else $error("dma tx request wrong");
  a_rx_int_level: assert property ($past(RST_B) && $stable(RX_LEVEL) && $stable(LVL)
    |-> RX_INT == (RX_LEVEL >= LVL.rx_thr || RX_LEVEL == 4'h8)) else $error("rx flag wrong");
  a_dma_rx_level: assert property ($past(RST_B) && $stable(RX_LEVEL) && $stable(LVL)
    |-> DMA_RX_REQ == (RX_LEVEL >= LVL.dma_rx)) else $error("dma rx request wrong");
  a_busy_sel: assert property (BUSY |-> !SS_OUT_N) else $error("busy without select");
  a_start_cond: assert property ($fell(SS_OUT_N)
    |-> $past(SLV_SEL) && CFG.enable && CFG.master) else $error("start without select");
  a_sclk_half: assert property ($rose(SCLK_OUT) |-> SCLK_OUT[*5] ##1 !SCLK_OUT)
    else $error("serial clock half period wrong");
  a_rxo_txd_low: assert property ((CFG.transfer_mode_field == 2'h2 && !CFG.ssp && !MW.en && !SS_OUT_N)[*3]
    |-> !TXD_O) else $error("receive-only data out moved");
  a_slv_quiet: assert property ((!CFG.master && SS_IN_N)[*5] |-> !TXD_OE)
    else $error("unselected slave drives");
  a_slv_oe_gate: assert property ((!CFG.master && !CFG.slv_oe)[*2] |-> !TXD_OE)
    else $error("slave drives with output disabled");
  a_txe_hold: assert property (TXE_ERR && !TXE_CLR |=> TXE_ERR)
    else $error("tx empty error lost");
  a_txe_rxo: assert property ($rose(TXE_ERR) |-> $past(CFG.transfer_mode_field) != 2'h2)
    else $error("tx empty error in receive-only");
  c_xfer_done: cover property ($fell(BUSY));
  c_txe_set: cover property ($rose(TXE_ERR));
  c_rx_full: cover property (RX_LEVEL == 4'h8 && RX_INT);
endmodule // sts_checker
bind sts_top sts_checker i_chk (.CORE_CLK, .RST_B, .CFG, .MW, .LVL, .SLV_SEL, .TXE_CLR,
  .SS_IN_N, .TX_LEVEL, .RX_LEVEL, .BUSY, .TXE_ERR, .TX_INT, .RX_INT, .DMA_TX_REQ,
  .DMA_RX_REQ, .SCLK_OUT, .SS_OUT_N, .TXD_O, .TXD_OE);
`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "sts_defines.svh"
module tb_top;
  import sts_pkg::*;
  // columns: mode, frame-pulse, three-wire, words pushed, words sent, zero frames, rx kept
  // three-wire column: 1 master sends data, 2 sequential receive
  localparam int tab [7][7] = '{'{0, 0, 0, 2, 1, 0, 2}, '{1, 0, 0, 9, 1, 0, 0},
    '{2, 0, 0, 1, 0, 10, 8}, '{3, 0, 0, 2, 1, 2, 2}, '{3, 1, 0, 2, 1, 0, 2},
    '{0, 0, 1, 2, 1, 0, -1}, '{0, 0, 2, 1, 1, 3, 3}};
  logic        core_clk, rst_b, slv_sel, tx_wr, rx_rd, txe_clr, sclk_in, ss_in_n;
  logic [15:0] tx_wdata, sw, rx_rdata, p_got;
  logic [3:0]  tx_level, rx_level;
  logic        tx_full, rx_empty, busy, txe_err, tx_int, rx_int, dtx, drx;
  logic        sclk_out, ss_out_n, txd_o, txd_oe, rxd;
  logic        rd_q = 1'b0;
  sts_cfg_s    cfg;
  sts_mw_s     mw;
  sts_lvl_s    lvl;
  int          p_nfr, fail_count = 0, checked = 0, seen = 0, cyc = 0;
  logic [15:0] txq [$];
  logic [15:0] rxq [$];
  sts_top i_dut (.CORE_CLK(core_clk), .RST_B(rst_b), .CFG(cfg), .MW(mw), .LVL(lvl),
    .SLV_SEL(slv_sel), .TX_WR(tx_wr), .TX_WDATA(tx_wdata), .RX_RD(rx_rd),
    .TXE_CLR(txe_clr), .RX_RDATA(rx_rdata), .TX_FULL(tx_full), .RX_EMPTY(rx_empty),
    .TX_LEVEL(tx_level), .RX_LEVEL(rx_level), .BUSY(busy), .TXE_ERR(txe_err),
    .TX_INT(tx_int), .RX_INT(rx_int), .DMA_TX_REQ(dtx), .DMA_RX_REQ(drx),
    .SCLK_OUT(sclk_out), .SS_OUT_N(ss_out_n), .TXD_O(txd_o), .TXD_OE(txd_oe),
    .RXD(rxd), .SCLK_IN(sclk_in), .SS_IN_N(ss_in_n));
  sts_slave_model i_slv (.sclk(sclk_out), .ss_n(ss_out_n), .txd(txd_o), .word(sw),
    .nbits(5'(cfg.len_m1) + 5'd1), .rxd(rxd), .got(p_got), .nfr(p_nfr));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic cyc_n(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic end_sim;
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // frames seen by the far side and popped receive words against the notes
  always @(posedge core_clk) begin
    if (p_nfr != seen) begin
      seen++;
      chk(16'(txq.size() > 0), 16'h0001, "unexpected frame");
      if (txq.size() > 0) chk(p_got, txq.pop_front(), "frame data");
    end
    if (rd_q) chk(rx_rdata, rxq.pop_front(), "rx word");
    rd_q <= rx_rd;
  end
  // ceiling well above the roughly 3100 cycles the run needs
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      end_sim;
    end
  end
  task automatic run_row(input int r);
    int          k;
    logic [15:0] d;
    cfg <= '{enable: 1'b1, master: 1'b1, ssp: 1'(tab[r][1]), transfer_mode_field: 2'(tab[r][0]),
      len_m1: 4'h7, frame_count_field: 16'(tab[r][5] > 0 ? tab[r][5] - 1 : 0), slv_oe: 1'b1};
    mw  <= '{en: 1'(tab[r][2] != 0), hs: 1'b0, dir: 1'(tab[r][2] != 2),
      seq: 1'(tab[r][2] == 2)};
    lvl <= '{4'($urandom_range(8)), 4'($urandom_range(8)), 4'($urandom_range(8)),
      4'($urandom_range(8))};
    sw  <= 16'($urandom);
    for (k = 0; k < tab[r][3]; k++) begin
      @(posedge core_clk);
      d = 16'($urandom);
      tx_wr    <= 1'b1;
      tx_wdata <= d;
      if (tab[r][4] != 0 && k < 8) txq.push_back({8'h00, d[7:0]});
    end
    @(posedge core_clk);
    tx_wr <= 1'b0;
    repeat (tab[r][5]) txq.push_back(16'h0000);
    cyc_n(3);
    chk(16'(tx_level), 16'(tab[r][3] > 8 ? 8 : tab[r][3]), "tx level");
    chk(16'(tx_full), 16'(tab[r][3] >= 8), "tx full");
    slv_sel <= 1'b1;
    k = 0;
    while (busy !== 1'b1 && k < 100) begin @(posedge core_clk); k++; end
    k = 0;
    while (busy === 1'b1 && k < 4000) begin @(posedge core_clk); k++; end
    chk(16'(k < 4000), 16'h0001, "busy stuck");
    slv_sel <= 1'b0;
    cyc_n(4);
    chk(16'(txq.size()), 16'h0000, "frames missing");
    if (tab[r][6] >= 0) begin
      chk(16'(rx_level), 16'(tab[r][6]), "rx level");
      for (k = 0; k < tab[r][6]; k++) begin
        @(posedge core_clk);
        rx_rd <= 1'b1;
        rxq.push_back({8'h00, sw[7:0]});
      end
      @(posedge core_clk);
      rx_rd <= 1'b0;
      cyc_n(3);
      chk(16'(rx_empty), 16'h0001, "rx drained");
    end
  endtask
  // the link clock runs only while the slave is selected
  task automatic slv_frame(input logic oe_exp, input logic err_exp);
    @(posedge core_clk);
    ss_in_n <= 1'b0;
    repeat (8) begin
      #80 sclk_in = 1'b1;
      #80 sclk_in = 1'b0;
    end
    chk(16'(txd_oe), 16'(oe_exp), "slave drive");
    chk(16'(txe_err), 16'(err_exp), "tx empty error");
    #80;
    @(posedge core_clk);
    ss_in_n <= 1'b1;
    cyc_n(6);
    chk(16'(txd_oe), 16'h0000, "slave released");
  endtask
  initial begin
    {rst_b, slv_sel, tx_wr, rx_rd, txe_clr, sclk_in} = '0;
    ss_in_n  = 1'b1;
    tx_wdata = 16'h0000;
    sw       = 16'h0000;
    cfg      = '0;
    mw       = '0;
    lvl      = '0;
    void'($urandom(25319));
    cyc_n(3);
    rst_b <= 1'b1;
    cyc_n(2);
    for (int r = 0; r < 7; r++) run_row(r);
    cfg <= '{enable: 1'b1, master: 1'b0, ssp: 1'b0, transfer_mode_field: 2'h0, len_m1: 4'h7,
      frame_count_field: 16'h0000, slv_oe: 1'b1};
    mw  <= '0;
    cyc_n(8);
    slv_frame(1'b1, 1'b1);
    txe_clr <= 1'b1;
    @(posedge core_clk);
    txe_clr <= 1'b0;
    cyc_n(3);
    chk(16'(txe_err), 16'h0000, "error clear");
    cfg.transfer_mode_field   <= 2'h2;
    cfg.slv_oe <= 1'b0;
    cyc_n(8);
    slv_frame(1'b0, 1'b0);
    cyc_n(5);
    end_sim;
  end
endmodule // tb_top
`default_nettype wire
